// ==== hdl/opac_top.sv ====
// Oscillator phase alignment control, key registers and coarse group delay.
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "opac_map.svh"

// How it works
// - Each channel has a 4-bit coarse group delay code, 0 smallest and 15 largest.
// - The code maps to a delay of -4 to +3.5 clock periods in half-period steps.
// - Only a zero-to-one write of the arm bit starts an alignment.
// - The mode field picks the trigger: 10 for a data key match, 01 for the timing pulse.
// - In key mode the match flag is set when the key matched during the armed alignment.
// - An alignment that ends without a data match leaves the match flag low.
// - The pass flag rises once the alignment has taken effect and is low before.
// - The fail flag rises if the trigger lands while the oscillator rotates.
// - Two 16-bit keys for I and Q live in low and high byte registers, reset to zero.
module opac_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic sysref_i,
    input wire logic [15:0] i_data_i,
    input wire logic [15:0] q_data_i,
    input wire logic osc_rotating_i,
    output logic osc_align_o,
    output logic osc_phase_align_armed_o,
    output logic [3:0] i_chan_group_delay_o,
    output logic [3:0] q_chan_group_delay_o,
    output logic signed [4:0] i_chan_delay_half_o,
    output logic signed [4:0] q_chan_delay_half_o,
    output logic irq_o
);
    opac_trig_if trig ();

    // Register contents.
    logic [3:0] i_chan_group_delay;
    logic [3:0] q_chan_group_delay;
    logic osc_phase_align_arm;
    logic osc_phase_key_matched;
    logic osc_phase_align_ok;
    logic osc_phase_align_err;
    opac_pkg::opac_trig_t osc_phase_trigger_sel;
    logic [15:0] i_chan_align_key;
    logic [15:0] q_chan_align_key;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [7:0] rdata;
    opac_pkg::opac_state_t state;
    logic align_pulse;

    logic [3:0] next_i_chan_group_delay;
    logic [3:0] next_q_chan_group_delay;
    logic next_osc_phase_align_arm;
    logic next_osc_phase_key_matched;
    logic next_osc_phase_align_ok;
    logic next_osc_phase_align_err;
    opac_pkg::opac_trig_t next_osc_phase_trigger_sel;
    logic [15:0] next_i_chan_align_key;
    logic [15:0] next_q_chan_align_key;
    logic [2:0] next_irq_stat;
    logic [2:0] next_irq_mask;
    logic [7:0] next_rdata;
    opac_pkg::opac_state_t next_state;
    logic next_align_pulse;

    logic wr_align;
    logic arm_rise;
    logic mode_on;
    logic [2:0] events;
    logic [2:0] w1c;

    opac_trig u_trig (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .sysref_i(sysref_i),
        .i_data_i(i_data_i),
        .q_data_i(q_data_i),
        .trig(trig)
    );

    // Detector sees the live mode and keys.
    assign trig.sel = osc_phase_trigger_sel;
    assign trig.key_i = i_chan_align_key;
    assign trig.key_q = q_chan_align_key;

    // Decode of the write that may arm; a level already high does not re-arm.
    always_comb begin
        wr_align = wr_i && (addr_i == `OPAC_OFS_ALIGN);
        arm_rise = wr_align && wdata_i[`OPAC_BIT_ARM] && !osc_phase_align_arm;
        mode_on = (osc_phase_trigger_sel == opac_pkg::OPAC_TRIG_KEY) ||
            (osc_phase_trigger_sel == opac_pkg::OPAC_TRIG_TIMING);
    end

    // Alignment sequence: armed waits for the selected trigger, then reports the outcome.
    always_comb begin
        next_state = state;
        next_osc_phase_key_matched = osc_phase_key_matched;
        next_osc_phase_align_ok = osc_phase_align_ok;
        next_osc_phase_align_err = osc_phase_align_err;
        next_align_pulse = 1'b0;
        unique case (state)
            opac_pkg::OPAC_IDLE: begin
                if (arm_rise && mode_on) begin
                    // A new run clears the previous outcome; flags read 0 until finished.
                    next_state = opac_pkg::OPAC_ARMED;
                    next_osc_phase_key_matched = 1'b0;
                    next_osc_phase_align_ok = 1'b0;
                    next_osc_phase_align_err = 1'b0;
                end
            end
            opac_pkg::OPAC_ARMED: begin
                if (!mode_on) begin
                    // Disabling the mode abandons the run with flags untouched.
                    next_state = opac_pkg::OPAC_IDLE;
                end else if (trig.hit) begin
                    next_state = opac_pkg::OPAC_IDLE;
                    if (osc_rotating_i) begin
                        next_osc_phase_align_err = 1'b1;
                    end else begin
                        next_osc_phase_align_ok = 1'b1;
                        next_align_pulse = 1'b1;
                    end
                    next_osc_phase_key_matched =
                        (osc_phase_trigger_sel == opac_pkg::OPAC_TRIG_KEY);
                end
            end
        endcase
    end

    // Software writable fields.
    always_comb begin
        next_i_chan_group_delay = i_chan_group_delay;
        next_q_chan_group_delay = q_chan_group_delay;
        next_osc_phase_align_arm = osc_phase_align_arm;
        next_osc_phase_trigger_sel = osc_phase_trigger_sel;
        next_i_chan_align_key = i_chan_align_key;
        next_q_chan_align_key = q_chan_align_key;
        next_irq_mask = irq_mask;
        w1c = 3'h0;
        if (wr_i) begin
            unique case (addr_i)
                `OPAC_OFS_GROUP_DLY: begin
                    next_i_chan_group_delay = wdata_i[`OPAC_GD_I_MSB:`OPAC_GD_I_LSB];
                    next_q_chan_group_delay = wdata_i[`OPAC_GD_Q_MSB:`OPAC_GD_Q_LSB];
                end
                `OPAC_OFS_ALIGN: begin
                    next_osc_phase_align_arm = wdata_i[`OPAC_BIT_ARM];
                    next_osc_phase_trigger_sel = opac_pkg::opac_trig_t'(
                        wdata_i[`OPAC_MODE_MSB:`OPAC_MODE_LSB]);
                end
                `OPAC_OFS_KEY_I_LO: next_i_chan_align_key[7:0] = wdata_i;
                `OPAC_OFS_KEY_I_HI: next_i_chan_align_key[15:8] = wdata_i;
                `OPAC_OFS_KEY_Q_LO: next_q_chan_align_key[7:0] = wdata_i;
                `OPAC_OFS_KEY_Q_HI: next_q_chan_align_key[15:8] = wdata_i;
                `OPAC_OFS_IRQ_STAT: w1c = wdata_i[2:0];
                `OPAC_OFS_IRQ_MASK: next_irq_mask = wdata_i[2:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky events; a set in the cycle of a clear wins so no event is lost.
    always_comb begin
        events = 3'h0;
        events[`OPAC_IRQ_OK] = next_osc_phase_align_ok && !osc_phase_align_ok;
        events[`OPAC_IRQ_ERR] = next_osc_phase_align_err && !osc_phase_align_err;
        events[`OPAC_IRQ_MATCH] = next_osc_phase_key_matched && !osc_phase_key_matched;
        next_irq_stat = (irq_stat & ~w1c) | events;
    end

    // Read mux; unmapped addresses and reserved bits read zero.
    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `OPAC_OFS_GROUP_DLY: next_rdata = {i_chan_group_delay, q_chan_group_delay};
                `OPAC_OFS_ALIGN: begin
                    next_rdata[`OPAC_BIT_ARM] = osc_phase_align_arm;
                    next_rdata[`OPAC_BIT_MATCH] = osc_phase_key_matched;
                    next_rdata[`OPAC_BIT_OK] = osc_phase_align_ok;
                    next_rdata[`OPAC_BIT_ERR] = osc_phase_align_err;
                    next_rdata[`OPAC_MODE_MSB:`OPAC_MODE_LSB] = osc_phase_trigger_sel;
                end
                `OPAC_OFS_KEY_I_LO: next_rdata = i_chan_align_key[7:0];
                `OPAC_OFS_KEY_I_HI: next_rdata = i_chan_align_key[15:8];
                `OPAC_OFS_KEY_Q_LO: next_rdata = q_chan_align_key[7:0];
                `OPAC_OFS_KEY_Q_HI: next_rdata = q_chan_align_key[15:8];
                `OPAC_OFS_IRQ_STAT: next_rdata = {5'h00, irq_stat};
                `OPAC_OFS_IRQ_MASK: next_rdata = {5'h00, irq_mask};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            i_chan_group_delay <= `OPAC_RST_GD_CODE;
            q_chan_group_delay <= `OPAC_RST_GD_CODE;
            osc_phase_align_arm <= 1'b0;
            osc_phase_key_matched <= 1'b0;
            osc_phase_align_ok <= 1'b0;
            osc_phase_align_err <= 1'b0;
            osc_phase_trigger_sel <= opac_pkg::OPAC_TRIG_OFF;
            i_chan_align_key <= `OPAC_RST_KEY;
            q_chan_align_key <= `OPAC_RST_KEY;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            rdata <= `OPAC_RST_BYTE;
            state <= opac_pkg::OPAC_IDLE;
            align_pulse <= 1'b0;
        end else begin
            i_chan_group_delay <= next_i_chan_group_delay;
            q_chan_group_delay <= next_q_chan_group_delay;
            osc_phase_align_arm <= next_osc_phase_align_arm;
            osc_phase_key_matched <= next_osc_phase_key_matched;
            osc_phase_align_ok <= next_osc_phase_align_ok;
            osc_phase_align_err <= next_osc_phase_align_err;
            osc_phase_trigger_sel <= next_osc_phase_trigger_sel;
            i_chan_align_key <= next_i_chan_align_key;
            q_chan_align_key <= next_q_chan_align_key;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata <= next_rdata;
            state <= next_state;
            align_pulse <= next_align_pulse;
        end
    end

    // Code 8 is the zero point: code minus 8 half periods spans -4 to +3.5 periods.
    always_comb begin
        rdata_o = rdata;
        osc_align_o = align_pulse;
        osc_phase_align_armed_o = (state == opac_pkg::OPAC_ARMED);
        i_chan_group_delay_o = i_chan_group_delay;
        q_chan_group_delay_o = q_chan_group_delay;
        i_chan_delay_half_o = $signed({1'b0, i_chan_group_delay}) - 5'sd8;
        q_chan_delay_half_o = $signed({1'b0, q_chan_group_delay}) - 5'sd8;
        irq_o = |(irq_stat & irq_mask);
    end
endmodule : opac_top

// ==== hdl/opac_map.svh ====
// Register offsets, field positions, reset values and code limits of the alignment block.
`ifndef OPAC_MAP_SVH
`define OPAC_MAP_SVH

`define OPAC_ADDR_W 8
`define OPAC_OFS_GROUP_DLY 8'h4f
`define OPAC_OFS_ALIGN 8'h50
`define OPAC_OFS_KEY_I_LO 8'h51
`define OPAC_OFS_KEY_I_HI 8'h52
`define OPAC_OFS_KEY_Q_LO 8'h53
`define OPAC_OFS_KEY_Q_HI 8'h54
`define OPAC_OFS_IRQ_STAT 8'h55
`define OPAC_OFS_IRQ_MASK 8'h56

`define OPAC_BIT_ARM 7
`define OPAC_BIT_MATCH 5
`define OPAC_BIT_OK 4
`define OPAC_BIT_ERR 3
`define OPAC_MODE_LSB 0
`define OPAC_MODE_MSB 1
`define OPAC_GD_I_LSB 4
`define OPAC_GD_I_MSB 7
`define OPAC_GD_Q_LSB 0
`define OPAC_GD_Q_MSB 3

`define OPAC_IRQ_OK 0
`define OPAC_IRQ_ERR 1
`define OPAC_IRQ_MATCH 2

`define OPAC_RST_GD_CODE 4'h8
`define OPAC_RST_KEY 16'h0000
`define OPAC_RST_BYTE 8'h00
`define OPAC_GD_MAX_CODE 4'hf

`endif

// ==== hdl/opac_pkg.sv ====
// Types shared by the oscillator phase alignment modules.
package opac_pkg;
    typedef enum logic [1:0] {
        OPAC_TRIG_OFF = 2'h0,
        OPAC_TRIG_TIMING = 2'h1,
        OPAC_TRIG_KEY = 2'h2,
        OPAC_TRIG_SPARE = 2'h3
    } opac_trig_t;

    typedef enum {
        OPAC_IDLE,
        OPAC_ARMED
    } opac_state_t;
endpackage : opac_pkg

// ==== hdl/opac_trig_if.sv ====
// Connection between the alignment controller and its trigger detector.
`timescale 1ns/10ps
interface opac_trig_if;
    opac_pkg::opac_trig_t sel;
    logic [15:0] key_i;
    logic [15:0] key_q;
    logic hit;

    modport ctl (output sel, output key_i, output key_q, input hit);
    modport det (input sel, input key_i, input key_q, output hit);
endinterface : opac_trig_if

// ==== hdl/opac_trig.sv ====
// Trigger detector: synchronised timing pulse edge or data key match.
`timescale 1ns/10ps
module opac_trig (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic sysref_i,
    input wire logic [15:0] i_data_i,
    input wire logic [15:0] q_data_i,
    opac_trig_if.det trig
);
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic next_sync_a;
    logic next_sync_b;
    logic next_sync_c;

    // The pin is asynchronous; only the second and third stages feed the edge detector.
    always_comb begin
        next_sync_a = sysref_i;
        next_sync_b = sync_a;
        next_sync_c = sync_b;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            sync_c <= next_sync_c;
        end
    end

    // Data samples come from the same clock, so the key compare is direct.
    always_comb begin
        unique case (trig.sel)
            opac_pkg::OPAC_TRIG_KEY: trig.hit = (i_data_i == trig.key_i) &&
                (q_data_i == trig.key_q);
            opac_pkg::OPAC_TRIG_TIMING: trig.hit = sync_b && !sync_c;
            default: trig.hit = 1'b0;
        endcase
    end
endmodule : opac_trig

// ==== test/opac_top_monitor.sv ====
// Concurrent checks on the ports of the alignment block.
`timescale 1ns/10ps
`include "opac_map.svh"
module opac_top_monitor (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic osc_rotating_i,
    input wire logic osc_align_o,
    input wire logic osc_phase_align_armed_o,
    input wire logic [3:0] i_chan_group_delay_o,
    input wire logic [3:0] q_chan_group_delay_o,
    input wire logic signed [4:0] i_chan_delay_half_o,
    input wire logic signed [4:0] q_chan_delay_half_o
);
    // All checks run on the one clock and rest while reset is low.
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside read cycle");
    a_i_delay_map: assert property (i_chan_delay_half_o ==
        $signed({1'b0, i_chan_group_delay_o}) - 5'sd8)
        else $error("I delay does not follow its code");
    a_q_delay_map: assert property (q_chan_delay_half_o ==
        $signed({1'b0, q_chan_group_delay_o}) - 5'sd8)
        else $error("Q delay does not follow its code");
    a_gd_write: assert property ($past(wr_i && addr_i == `OPAC_OFS_GROUP_DLY) |->
        {i_chan_group_delay_o, q_chan_group_delay_o} == $past(wdata_i))
        else $error("group delay codes not taken from write");
    a_gd_hold: assert property (!$past(wr_i && addr_i == `OPAC_OFS_GROUP_DLY) |->
        $stable({i_chan_group_delay_o, q_chan_group_delay_o}))
        else $error("group delay codes changed without write");
    a_arm_cause: assert property ($rose(osc_phase_align_armed_o) |->
        $past(wr_i && addr_i == `OPAC_OFS_ALIGN && wdata_i[7]))
        else $error("armed without an arm write");
    a_align_cause: assert property (osc_align_o |->
        $past(osc_phase_align_armed_o) && !$past(osc_rotating_i) && !osc_phase_align_armed_o)
        else $error("alignment pulse without armed trigger");
    a_align_pulse: assert property (osc_align_o |=> !osc_align_o)
        else $error("alignment pulse longer than one cycle");
endmodule : opac_top_monitor

bind opac_top opac_top_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .osc_rotating_i(osc_rotating_i), .osc_align_o(osc_align_o),
    .osc_phase_align_armed_o(osc_phase_align_armed_o),
    .i_chan_group_delay_o(i_chan_group_delay_o), .q_chan_group_delay_o(q_chan_group_delay_o),
    .i_chan_delay_half_o(i_chan_delay_half_o), .q_chan_delay_half_o(q_chan_delay_half_o));

// ==== test/opac_top_tb_top.sv ====
// Register level testbench for the alignment block.
`timescale 1ns/10ps
module opac_top_tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic sysref_i = 1'b0;
    logic [15:0] i_data_i = 16'h0000;
    logic [15:0] q_data_i = 16'h0000;
    logic osc_rotating_i = 1'b0;
    logic [7:0] rdata_o;
    logic osc_align_o;
    logic armed;
    logic [3:0] gd_i;
    logic [3:0] gd_q;
    logic signed [4:0] dh_i;
    logic signed [4:0] dh_q;
    logic irq_o;
    logic seen;
    int fail_count = 0;
    int cmp_count = 0;
    // Clock of 100 MHz.
    always #5 clk_i = ~clk_i;
    opac_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sysref_i(sysref_i),
        .i_data_i(i_data_i), .q_data_i(q_data_i), .osc_rotating_i(osc_rotating_i),
        .osc_align_o(osc_align_o), .osc_phase_align_armed_o(armed),
        .i_chan_group_delay_o(gd_i), .q_chan_group_delay_o(gd_q),
        .i_chan_delay_half_o(dh_i), .q_chan_delay_half_o(dh_q), .irq_o(irq_o));
    // Verdict and end of run; also the landing place of a timed out wait.
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test
    // Case inequality, so an unknown value never counts as a match.
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // One cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so they are sampled there.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata_o});
    endtask : rd
    // Bounded wait for the armed state to end, noting any alignment pulse on the way.
    task automatic wait_done();
        int n;
        seen = 1'b0;
        for (n = 0; n < 20 && armed === 1'b1; n++) begin
            @(posedge clk_i);
            #1;
            if (osc_align_o === 1'b1) seen = 1'b1;
        end
        if (armed !== 1'b0) begin
            fail_count++;
            stop_test();
        end
    endtask : wait_done
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        chk("gd_i", 16'h0008, gd_i);
        chk("dh_q", 16'h0000, $unsigned(dh_q));
        rd(8'h4f, 8'h88);
        rd(8'h50, 8'h00);
        for (int a = 8'h51; a <= 8'h54; a++) rd(8'(a), 8'h00);
        rd(8'h70, 8'h00);
        $display("test reset done");
        for (int c = 0; c <= 15; c += 15) begin
            wr(8'h4f, {4'(c), 4'(15 - c)});
            chk("gd_i", 16'(c), gd_i);
            chk("gd_q", 16'(15 - c), gd_q);
            chk("dh_i", {11'h0, 5'(c - 8)}, $unsigned(dh_i));
            chk("dh_q", {11'h0, 5'(7 - c)}, $unsigned(dh_q));
            rd(8'h4f, {4'(c), 4'(15 - c)});
        end
        $display("test group delay done");
        wr(8'h51, 8'h12);
        wr(8'h52, 8'h34);
        wr(8'h53, 8'h56);
        wr(8'h54, 8'h78);
        for (int a = 0; a < 4; a++) rd(8'(8'h51 + a), 8'(8'h12 + 8'h22 * a));
        wr(8'h50, 8'h80);
        chk("armed", 16'h0, armed);
        rd(8'h50, 8'h80);
        $display("test disabled done");
        wr(8'h50, 8'h02);
        wr(8'h50, 8'h82);
        chk("armed", 16'h1, armed);
        i_data_i <= 16'h3412;
        repeat (3) @(posedge clk_i);
        #1;
        chk("armed", 16'h1, armed);
        q_data_i <= 16'h7856;
        wait_done();
        chk("align", 16'h1, seen);
        rd(8'h50, 8'hb2);
        rd(8'h55, 8'h05);
        chk("irq", 16'h0, irq_o);
        wr(8'h56, 8'h01);
        chk("irq", 16'h1, irq_o);
        wr(8'h55, 8'h01);
        chk("irq", 16'h0, irq_o);
        rd(8'h55, 8'h04);
        $display("test key align done");
        wr(8'h50, 8'h01);
        wr(8'h50, 8'h81);
        sysref_i <= 1'b1;
        osc_rotating_i <= 1'b1;
        wait_done();
        chk("align", 16'h0, seen);
        rd(8'h50, 8'h89);
        rd(8'h55, 8'h06);
        sysref_i <= 1'b0;
        osc_rotating_i <= 1'b0;
        $display("test fail done");
        wr(8'h50, 8'h01);
        wr(8'h50, 8'h81);
        rd(8'h50, 8'h81);
        sysref_i <= 1'b1;
        wait_done();
        chk("align", 16'h1, seen);
        rd(8'h50, 8'h91);
        chk("irq", 16'h1, irq_o);
        sysref_i <= 1'b0;
        wr(8'h50, 8'h81);
        chk("armed", 16'h0, armed);
        $display("test timing align done");
        stop_test();
    end
endmodule : opac_top_tb_top
